/* design/fpcl_loader.sv */
// Purpose: Configuration loader, master flash and slave serial
// Assumes: SER_CLK from host only in slave serial mode
// Notes:   Open-drain pins as out/enable pairs, enable high = drive
//
// Contract
// - Drive 24 address lines during configuration
// - Upper user address lines high when swap 0
// - Configuration reads bytes only; user x8/x16
// - Upper data bits on extra user pins
// - Width select low in config, high x16
// - Drive output enable, chip select, write enable
// - Lowest address pin doubles as D15 later
// - After own load keep addressing, chain select low
// - Master outputs config clock for chain capture
// - Init low while clearing; sample mode at release
// - Check error drives init low
// - Done low until successful completion
// - Program low 500 ns restarts on release
// - Serial bit captured on SER_CLK rising
// - Serial chain stream up to 4294967264 bits
// - Internal clock starts slowest, rate from stream
`timescale 1ns/1ns
module fpcl_loader
  import fpcl_pkg::*;
#(
  parameter int CFG_BYTES = 16
) (
  input  wire logic              MCLK,
  input  wire logic              RESETN,
  input  wire logic              SER_CLK,
  input  wire logic              SER_DIN,
  output      logic              SER_DOUT,
  input  wire logic [2:0]        MODE,
  input  wire logic              PULLUP_SWAP_SELECT,
  input  wire logic              PROGRAM_REQUEST_N,
  input  wire logic              INIT_N_I,
  output      logic              INIT_N_O,
  output      logic              INIT_N_OE,
  output      logic              DONE_O,
  output      logic              DONE_OE,
  output      fpcl_flash_t       FLASH,
  output      logic              CONFIG_CLOCK_OUT,
  output      logic              CHAIN_SELECT_OUT_N,
  input  wire logic              TOP_PIN_I,
  output      logic              TOP_PIN_O,
  output      logic              TOP_PIN_OE,
  input  wire logic [7:0]        DLO_I,
  output      logic [7:0]        DLO_O,
  output      logic              DLO_OE,
  input  wire logic [6:0]        DHI_I,
  output      logic [6:0]        DHI_O,
  output      logic              DHI_OE,
  output      logic [AHI_W-1:0]  AHI_O,
  output      logic              AHI_OE,
  input  wire logic              CHAIN_EN,
  input  wire logic              USER_X16,
  input  wire logic              USER_CS_N,
  input  wire logic              USER_OE_N,
  input  wire logic              USER_WE_N,
  input  wire logic [31:0]       USER_ADDR,
  input  wire logic [15:0]       USER_WDATA,
  output      logic [15:0]       USER_RDATA,
  output      logic              BUSY
);

  // ========================================================
  // Rate code to half period, slowest default
  function automatic logic [5:0] rate_half(input logic [1:0] c);
    logic [5:0] h;
    h = HALF_SLOW;
    if (c == 2'h1) h = HALF_R1;
    else if (c == 2'h2) h = HALF_R2;
    else if (c == 2'h3) h = HALF_R3;
    return h;
  endfunction

  // ========================================================
  // Pin synchronisers, MCLK side
  logic [1:0] prog_q, init_q;
  logic [2:0] mode_q1, mode_q2;
  logic [1:0] swap_q;
  logic [7:0] dlo_q1, dlo_q2;
  logic [6:0] dhi_q1, dhi_q2;
  logic [1:0] top_q;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      prog_q  <= 2'h0;
      init_q  <= 2'h0;
      mode_q1 <= 3'h0;
      mode_q2 <= 3'h0;
      swap_q  <= 2'h0;
      dlo_q1  <= 8'h00;
      dlo_q2  <= 8'h00;
      dhi_q1  <= 7'h00;
      dhi_q2  <= 7'h00;
      top_q   <= 2'h0;
    end else begin
      prog_q  <= {prog_q[0], PROGRAM_REQUEST_N};
      init_q  <= {init_q[0], INIT_N_I};
      mode_q1 <= MODE;
      mode_q2 <= mode_q1;
      swap_q  <= {swap_q[0], PULLUP_SWAP_SELECT};
      dlo_q1  <= DLO_I;
      dlo_q2  <= dlo_q1;
      dhi_q1  <= DHI_I;
      dhi_q2  <= dhi_q1;
      top_q   <= {top_q[0], TOP_PIN_I};
    end
  end

  fpcl_state_t st_r;
  logic        restart;

  // ========================================================
  // Program request low-time qualifier
  logic [7:0] plow_r;
  logic       prog_armed;
  assign prog_armed = (plow_r >= 8'(PROG_MIN_CYC));
  assign restart    = prog_q[1] && prog_armed;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) plow_r <= 8'h00;
    else if (prog_q[1]) plow_r <= 8'h00;
    else if (!prog_armed) plow_r <= plow_r + 8'h01;
  end

  // ========================================================
  // Serial link domain: capture, pack, forward
  logic [1:0] act_s, fwd_s;
  logic [7:0] sh_r, hold_r;
  logic [2:0] bc_r;
  logic       tog_r;
  logic [31:0] bits_r;
  always_ff @(posedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      act_s <= 2'h0;
      fwd_s <= 2'h0;
    end else begin
      act_s <= {act_s[0], (st_r == ST_LDS) || (st_r == ST_SUP)};
      fwd_s <= {fwd_s[0], (st_r == ST_RUN)};
    end
  end
  // Bits shift in MSB first on each rising edge
  always_ff @(posedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sh_r   <= 8'h00;
      hold_r <= 8'h00;
      bc_r   <= 3'h0;
      tog_r  <= 1'b0;
    end else if (!act_s[1]) begin
      bc_r <= 3'h0;
    end else begin
      sh_r <= {sh_r[6:0], SER_DIN};
      bc_r <= bc_r + 3'h1;
      if (bc_r == 3'h7) begin
        hold_r <= {sh_r[6:0], SER_DIN};
        tog_r  <= ~tog_r;
      end
    end
  end
  // Stream length and pass-through once own load is done
  always_ff @(posedge SER_CLK or negedge RESETN) begin
    if (!RESETN) begin
      bits_r   <= 32'h0;
      SER_DOUT <= 1'b1;
    end else begin
      if (act_s[1] || fwd_s[1]) begin
        if (bits_r != SER_MAX_BITS) bits_r <= bits_r + 32'h1;
      end else begin
        bits_r <= 32'h0;
      end
      // Forwarding stops at the chain limit, no wrap
      if (fwd_s[1] && bits_r != SER_MAX_BITS) SER_DOUT <= SER_DIN;
    end
  end

  // Byte toggle back into MCLK; hold_r is stable for 8 link clocks
  logic [2:0] tq_r;
  logic       sbyte_vld;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) tq_r <= 3'h0;
    else tq_r <= {tq_r[1:0], tog_r};
  end
  assign sbyte_vld = tq_r[2] ^ tq_r[1];

  // ========================================================
  // Internal config clock and flash address generator
  logic [5:0]        half_r, div_r;
  logic              config_clock_r;
  logic [ADDR_W-1:0] addr_r;
  logic              fbyte_vld, run_clk, config_clock_rise;
  assign run_clk   = (st_r == ST_LDF) || (st_r == ST_CHN) ||
                     ((st_r == ST_SUP) && (mode_q2 != MODE_SSER));
  assign config_clock_rise = run_clk && (div_r == 6'h00) && !config_clock_r;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      div_r  <= HALF_SLOW;
      config_clock_r <= 1'b0;
      addr_r <= ADDR_ZERO;
    end else if (!run_clk) begin
      div_r  <= HALF_SLOW;
      config_clock_r <= 1'b0;
      if (st_r == ST_CLR) addr_r <= ADDR_ZERO;
    end else if (div_r == 6'h00) begin
      div_r  <= half_r;
      config_clock_r <= ~config_clock_r;
      if (config_clock_r) addr_r <= addr_r + ADDR_ONE;
    end else begin
      div_r <= div_r - 6'h01;
    end
  end
  // Byte sampled at rising edge, address moves on falling
  assign fbyte_vld = config_clock_rise && (st_r == ST_LDF);

  // ========================================================
  // Loader sequencer
  logic [31:0] idx_r;
  logic [7:0]  chk_r, bval;
  logic [8:0]  cnt_r;
  logic [2:0]  msmp_r;
  logic        bvld;
  assign bvld = (st_r == ST_LDS) ? sbyte_vld : fbyte_vld;
  assign bval = (st_r == ST_LDS) ? hold_r : dlo_q2;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_r   <= ST_WAIT;
      cnt_r  <= 9'h000;
      idx_r  <= 32'h0;
      chk_r  <= 8'h00;
      msmp_r <= 3'h0;
      half_r <= HALF_SLOW;
    end else if (restart || (st_r == ST_WAIT && prog_q[1])) begin
      st_r   <= ST_CLR;
      cnt_r  <= 9'h000;
      half_r <= HALF_SLOW;
    end else begin
      case (st_r)
        ST_CLR: begin
          if (cnt_r != 9'(CLEAR_CYC)) begin
            cnt_r <= cnt_r + 9'h001;
          end else if (init_q[1]) begin
            // External init hold keeps us here
            msmp_r <= mode_q2;
            idx_r  <= 32'h0;
            chk_r  <= 8'h00;
            cnt_r  <= 9'h000;
            if (mode_q2 == MODE_FLASH_A || mode_q2 == MODE_FLASH_B)
              st_r <= ST_LDF;
            else if (mode_q2 == MODE_SSER)
              st_r <= ST_LDS;
          end
        end
        ST_LDF, ST_LDS: begin
          if (bvld) begin
            if (st_r == ST_LDF && idx_r == RATE_IDX)
              half_r <= rate_half(bval[1:0]);
            if (idx_r == 32'(CFG_BYTES - 1)) begin
              st_r <= (bval == chk_r) ? ST_SUP : ST_ERR;
            end else begin
              chk_r <= chk_r ^ bval;
              idx_r <= idx_r + 32'h1;
            end
          end
        end
        ST_SUP: begin
          // Serial start-up advances only on host clocks
          if (msmp_r == MODE_SSER) begin
            if (sbyte_vld) cnt_r <= cnt_r + 9'h001;
            if (cnt_r == 9'(STARTUP_SBYT)) st_r <= ST_RUN;
          end else begin
            cnt_r <= cnt_r + 9'h001;
            if (cnt_r == 9'(STARTUP_CYC))
              st_r <= CHAIN_EN ? ST_CHN : ST_RUN;
          end
        end
        default: st_r <= st_r;
      endcase
    end
  end

  // ========================================================
  // Status pins, open drain: enable high pulls low
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      INIT_N_O  <= 1'b0;
      INIT_N_OE <= 1'b1;
      DONE_O    <= 1'b0;
      DONE_OE   <= 1'b1;
      BUSY      <= 1'b1;
    end else begin
      INIT_N_O  <= 1'b0;
      INIT_N_OE <= (st_r == ST_CLR && cnt_r != 9'(CLEAR_CYC)) ||
                   (st_r == ST_WAIT) || (st_r == ST_ERR);
      DONE_O    <= 1'b0;
      DONE_OE   <= !(st_r == ST_RUN || st_r == ST_CHN);
      BUSY      <= !(st_r == ST_RUN || st_r == ST_CHN);
    end
  end

  // ========================================================
  // Flash pins: loader owns them until user phase
  logic cfg_own, user_ph, x16;
  assign cfg_own = !(st_r == ST_RUN);
  assign user_ph = (st_r == ST_RUN);
  assign x16     = user_ph && USER_X16;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      FLASH              <= '{addr: '0, oe_n: 1'b1, cs_n: 1'b1,
                              we_n: 1'b1, width: 1'b0};
      CONFIG_CLOCK_OUT   <= 1'b0;
      CHAIN_SELECT_OUT_N <= 1'b1;
      TOP_PIN_O          <= 1'b0;
      TOP_PIN_OE         <= 1'b0;
      AHI_O              <= {AHI_W{1'b1}};
      AHI_OE             <= 1'b0;
      DLO_O              <= 8'h00;
      DLO_OE             <= 1'b0;
      DHI_O              <= 7'h00;
      DHI_OE             <= 1'b0;
      USER_RDATA         <= 16'h0000;
    end else begin
      CONFIG_CLOCK_OUT   <= config_clock_r;
      CHAIN_SELECT_OUT_N <= !(st_r == ST_CHN);
      if (cfg_own) begin
        FLASH.addr  <= addr_r[ADDR_W-1:1];
        FLASH.oe_n  <= !run_clk;
        FLASH.cs_n  <= !run_clk;
        FLASH.we_n  <= 1'b1;
        FLASH.width <= 1'b0;
        TOP_PIN_O   <= addr_r[0];
        TOP_PIN_OE  <= 1'b1;
        // Emulated pull-up on user-pin address bits
        AHI_O  <= {AHI_W{1'b1}};
        AHI_OE <= !swap_q[1];
        DLO_OE <= 1'b0;
        DHI_OE <= 1'b0;
      end else begin
        FLASH.addr  <= USER_ADDR[ADDR_W-1:1];
        FLASH.oe_n  <= USER_OE_N;
        FLASH.cs_n  <= USER_CS_N;
        FLASH.we_n  <= USER_WE_N;
        FLASH.width <= x16;
        AHI_O  <= USER_ADDR[ADDR_W+AHI_W-1:ADDR_W];
        AHI_OE <= 1'b1;
        DLO_O  <= USER_WDATA[7:0];
        DLO_OE <= !USER_WE_N;
        DHI_O  <= USER_WDATA[14:8];
        DHI_OE <= x16 && !USER_WE_N;
        // Lowest address pin turns into D15 at x16
        TOP_PIN_O  <= x16 ? USER_WDATA[15] : USER_ADDR[0];
        TOP_PIN_OE <= x16 ? !USER_WE_N : 1'b1;
      end
      USER_RDATA <= x16 ? {top_q[1], dhi_q2, dlo_q2}
                        : {8'h00, dlo_q2};
    end
  end

endmodule

/* design/fpcl_pkg.sv */
// Purpose: Shared constants and types for the configuration loader
// Assumes: MCLK period of 4 ns
// Notes:   Program and clear times kept in ns, counts derived from them; start-up given as counts
package fpcl_pkg;
  // ==========================================================
  // Clock and timing
  localparam int MCLK_NS      = 4;
  localparam int PROG_MIN_NS  = 500;
  localparam int PROG_MIN_CYC = (PROG_MIN_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int CLEAR_NS     = 1000;
  localparam int CLEAR_CYC    = (CLEAR_NS + MCLK_NS - 1) / MCLK_NS;
  localparam int STARTUP_CYC  = 8;
  localparam int STARTUP_SBYT = 2;
  // ==========================================================
  // Widths and limits
  localparam int ADDR_W   = 24;
  localparam int AHI_W    = 8;
  localparam logic [31:0] SER_MAX_BITS = 32'hffffffe0;
  localparam logic [31:0] RATE_IDX     = 32'h00000000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 24'h000001;
  // ==========================================================
  // Mode pin codes
  localparam logic [2:0] MODE_FLASH_A = 3'h2;
  localparam logic [2:0] MODE_FLASH_B = 3'h3;
  localparam logic [2:0] MODE_SPAR    = 3'h6;
  localparam logic [2:0] MODE_SSER    = 3'h7;
  // ==========================================================
  // Config clock half periods, less one, in MCLK cycles, slowest first
  localparam logic [5:0] HALF_SLOW = 6'h20;
  localparam logic [5:0] HALF_R1   = 6'h10;
  localparam logic [5:0] HALF_R2   = 6'h08;
  localparam logic [5:0] HALF_R3   = 6'h04;
  // ==========================================================
  // Loader states
  typedef enum logic [7:0] {
    ST_WAIT = 8'h01,
    ST_CLR  = 8'h02,
    ST_LDF  = 8'h04,
    ST_LDS  = 8'h08,
    ST_SUP  = 8'h10,
    ST_RUN  = 8'h20,
    ST_CHN  = 8'h40,
    ST_ERR  = 8'h80
  } fpcl_state_t;
  // Flash control group driven toward the PROM
  typedef struct packed {
    logic [ADDR_W-1:1] addr;
    logic              oe_n;
    logic              cs_n;
    logic              we_n;
    logic              width;
  } fpcl_flash_t;
endpackage

/* verif/fpcl_flash_mdl.sv */
// Purpose: Behavioural parallel flash for the loader bench
// Assumes: Byte array filled by the bench before each load
// Notes:   Released bus shows the inverse of the addressed data
`timescale 1ns/1ns
module fpcl_flash_mdl
  import fpcl_pkg::*;
(
  input  wire fpcl_flash_t FLASH,
  input  wire logic        A_LOW,
  output logic [15:0]      DQ
);
  logic [7:0]  mem [0:63];
  logic [5:0]  hw;
  logic [15:0] word;
  // ==========================================================
  // Read path: width low makes the dual pin the byte address
  always @* begin
    hw   = {FLASH.addr[5:1], 1'b0};
    word = FLASH.width ? {mem[hw + 6'h01], mem[hw]}
         : {8'h00, mem[{FLASH.addr[5:1], A_LOW}]};
    // Never echo a stale byte once deselected
    DQ = (!FLASH.cs_n && !FLASH.oe_n && FLASH.we_n) ? word : ~word;
  end
endmodule

/* verif/fpcl_loader_asserts.sv */
// Purpose: Port checker for the configuration loader
// Assumes: Single MCLK domain, RESETN async active low
// Notes:   Bound to the loader at the foot of this file
`timescale 1ns/1ns
module fpcl_chk
  import fpcl_pkg::*;
#(
  parameter int CFG_BYTES = 16
) (
  input wire logic             MCLK,
  input wire logic             RESETN,
  input wire logic [2:0]       MODE,
  input wire logic             PULLUP_SWAP_SELECT,
  input wire logic             PROGRAM_REQUEST_N,
  input wire logic             INIT_N_OE,
  input wire logic             DONE_OE,
  input wire fpcl_flash_t      FLASH,
  input wire logic             CONFIG_CLOCK_OUT,
  input wire logic             CHAIN_SELECT_OUT_N,
  input wire logic             TOP_PIN_O,
  input wire logic [AHI_W-1:0] AHI_O,
  input wire logic             BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // ==========================================================
  // Helpers
  logic [7:0]  low_cnt_r;
  logic [9:0]  init_cnt_r;
  logic [23:0] baddr;
  logic        ld;
  // Byte address with the dual pin as A0; live while flash read
  assign baddr = {FLASH.addr, TOP_PIN_O};
  assign ld    = !FLASH.cs_n && (BUSY || !CHAIN_SELECT_OUT_N);
  // Run lengths saturate, so long waits never wrap to small
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      low_cnt_r  <= 8'h00;
      init_cnt_r <= 10'h000;
    end else begin
      low_cnt_r  <= PROGRAM_REQUEST_N ? 8'h00
                  : low_cnt_r + 8'(low_cnt_r != 8'hff);
      init_cnt_r <= !INIT_N_OE ? 10'h000
                  : init_cnt_r + 10'(init_cnt_r != 10'h3ff);
    end
  end
  // ==========================================================
  // Restart steps
  sequence s_long_rel;
    $rose(PROGRAM_REQUEST_N) && low_cnt_r >= 8'h7d;
  endsequence
  sequence s_restart;
    ##[1:8] (INIT_N_OE && DONE_OE);
  endsequence
  // ==========================================================
  // Checks
  AST_PROG_LONG: assert property (s_long_rel |-> s_restart)
    else $error("long program request did not restart");
  AST_PROG_SHORT: assert property ($rose(PROGRAM_REQUEST_N)
    && low_cnt_r < 8'h64 && !DONE_OE |-> ##1 !DONE_OE [*8])
    else $error("short program request had an effect");
  AST_CLEAR_LEN: assert property ($fell(INIT_N_OE)
    |-> init_cnt_r >= 10'h0f0)
    else $error("init released before clearing ended");
  AST_DONE_INIT: assert property ($fell(DONE_OE) |-> !INIT_N_OE)
    else $error("done released during an error");
  AST_CFG_CTRL: assert property ($fell(INIT_N_OE) &&
    (MODE == MODE_FLASH_A || MODE == MODE_FLASH_B)
    |-> ##[1:4] (!FLASH.cs_n && !FLASH.oe_n && FLASH.we_n))
    else $error("flash controls wrong at load start");
  AST_WIDTH_CFG: assert property (DONE_OE && $past(DONE_OE)
    |-> !FLASH.width)
    else $error("width select high during configuration");
  AST_UPPER_HIGH: assert property (DONE_OE && $past(DONE_OE) &&
    !PULLUP_SWAP_SELECT |-> AHI_O == 8'hff)
    else $error("upper address not high in configuration");
  AST_ADDR_STEP: assert property (ld && $past(ld) &&
    $changed(baddr) |-> baddr == $past(baddr) + 24'h000001)
    else $error("flash address skipped");
  AST_CLK_RUN: assert property (!CHAIN_SELECT_OUT_N
    |-> ##[1:70] $changed(CONFIG_CLOCK_OUT))
    else $error("config clock stalled in chain hand-off");
endmodule

bind fpcl_loader fpcl_chk #(.CFG_BYTES(CFG_BYTES)) chk_u (
  .MCLK(MCLK), .RESETN(RESETN), .MODE(MODE),
  .PULLUP_SWAP_SELECT(PULLUP_SWAP_SELECT),
  .PROGRAM_REQUEST_N(PROGRAM_REQUEST_N), .INIT_N_OE(INIT_N_OE),
  .DONE_OE(DONE_OE), .FLASH(FLASH), .CONFIG_CLOCK_OUT(CONFIG_CLOCK_OUT),
  .CHAIN_SELECT_OUT_N(CHAIN_SELECT_OUT_N), .TOP_PIN_O(TOP_PIN_O),
  .AHI_O(AHI_O), .BUSY(BUSY));

/* verif/tb_fpcl_loader.sv */
// Purpose: Self-checking bench for the configuration loader
// Assumes: MCLK 4 ns, serial clock 30 ns within frames, 5 ns pulses during reset
// Notes:   Four-byte image keeps each load short
`timescale 1ns/1ns
module tb_fpcl_loader
  import fpcl_pkg::*;
;
  localparam int NB = 4;
  logic        MCLK, RESETN, SER_CLK, SER_DIN, SER_DOUT, BUSY;
  logic        PULLUP_SWAP_SELECT, PROGRAM_REQUEST_N, CHAIN_EN;
  logic [2:0]  MODE;
  logic        INIT_N_I, INIT_N_O, INIT_N_OE, DONE_O, DONE_OE;
  fpcl_flash_t FLASH;
  logic        CONFIG_CLOCK_OUT, CHAIN_SELECT_OUT_N, AHI_OE;
  logic        TOP_PIN_I, TOP_PIN_O, TOP_PIN_OE, DLO_OE, DHI_OE;
  logic [7:0]  DLO_I, DLO_O, AHI_O;
  logic [6:0]  DHI_I, DHI_O;
  logic        USER_X16, USER_CS_N, USER_OE_N, USER_WE_N;
  logic [31:0] USER_ADDR, lf;
  logic [15:0] USER_WDATA, USER_RDATA, dq;
  logic [7:0]  img [0:63];
  logic [1:0]  exp_q [$];
  logic        armed, done_q, init_q;
  int          fail_count, comparisons;
  // ==========================================================
  // Wires: pull-up on init, flash bus resolved by enables
  assign INIT_N_I  = INIT_N_OE ? INIT_N_O : 1'b1;
  assign TOP_PIN_I = TOP_PIN_OE ? TOP_PIN_O : dq[15];
  assign DLO_I     = DLO_OE ? DLO_O : dq[7:0];
  assign DHI_I     = DHI_OE ? DHI_O : dq[14:8];
  fpcl_loader #(.CFG_BYTES(NB)) dut_u (.*);
  fpcl_flash_mdl flash_u (.FLASH(FLASH), .A_LOW(TOP_PIN_O), .DQ(dq));
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic check_val(input logic [15:0] got, want, input string m);
    comparisons++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] %0t %s: %h not %h", $time, m, got, want);
    end
  endtask
  task automatic chk1(input logic got, want, input string m);
    check_val({15'h0000, got}, {15'h0000, want}, m);
  endtask
  task automatic check_st(input logic [1:0] got, want);
    check_val({14'h0000, got}, {14'h0000, want}, "end status");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Random image, fastest rate code, check byte last
  task automatic load_img(input logic bad);
    logic [7:0] x;
    x = 8'h00;
    for (int i = 0; i < 64; i++) begin
      lf = lfsr(lf);
      img[i] = (i == 0) ? {lf[7:2], 2'b11} : lf[7:0];
      if (i < NB - 1) x = x ^ img[i];
    end
    img[NB - 1] = x ^ {7'h00, bad};
    flash_u.mem = img;
  endtask
  task automatic prog(input int n);
    PROGRAM_REQUEST_N = 1'b0;
    tick(n);
    PROGRAM_REQUEST_N = 1'b1;
  endtask
  task automatic do_reset;
    RESETN = 1'b0;
    fork
      tick(4);
      repeat (2) begin
        #2 SER_CLK = 1'b1;
        #3 SER_CLK = 1'b0;
      end
    join
    RESETN = 1'b1;
  endtask
  // Arm only once clearing is over, so its init rise is ignored
  task automatic arm;
    int k;
    for (k = 0; INIT_N_OE !== 1'b1 && k < 40; k++) tick(1);
    for (k = 0; INIT_N_OE !== 1'b0 && k < 700; k++) tick(1);
    armed = 1'b1;
  endtask
  task automatic fin(input string t);
    int k;
    for (k = 0; armed && k < 4000; k++) tick(1);
    if (armed) begin
      fail_count++;
      $display("[FAIL] %0t no end status in %s", $time, t);
    end
    $display("test %s done", t);
  endtask
  task automatic ser_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      SER_DIN = b[i];
      #7 SER_CLK = 1'b1;
      #15 SER_CLK = 1'b0;
      #8;
    end
  endtask
  task automatic take(input logic [1:0] got);
    armed = 1'b0;
    if (exp_q.size() == 0) begin
      fail_count++;
      $display("[FAIL] %0t unexpected end status", $time);
    end else begin
      check_st(got, exp_q.pop_front());
    end
  endtask
  // ==========================================================
  // Watcher: done release or init error ends a load
  always @(posedge MCLK) begin
    done_q <= DONE_OE;
    init_q <= INIT_N_OE;
    if (armed && done_q === 1'b1 && DONE_OE === 1'b0) begin
      take(2'h1);
    end else if (armed && init_q === 1'b0 && INIT_N_OE === 1'b1) begin
      take(2'h2);
    end
  end
  initial begin
    #300000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end
  // ==========================================================
  // Main sequence
  initial begin
    lf = 32'h00012df2;
    {SER_CLK, SER_DIN, CHAIN_EN, PULLUP_SWAP_SELECT, USER_X16} = 5'h00;
    {PROGRAM_REQUEST_N, USER_CS_N, USER_OE_N, USER_WE_N} = 4'hf;
    {USER_ADDR, USER_WDATA} = 48'h000000000000;
    {MODE, armed} = {MODE_FLASH_A, 1'b0};
    load_img(1'b0);
    do_reset;
    chk1(DONE_OE, 1'b1, "done at reset");
    chk1(FLASH.cs_n, 1'b1, "cs at reset");
    exp_q.push_back(2'h1);
    arm;
    chk1(FLASH.width, 1'b0, "width in load");
    fin("master_load");
    chk1(BUSY, 1'b0, "busy after load");
    USER_ADDR = 32'h0000000a;
    {USER_X16, USER_CS_N, USER_OE_N} = 3'h4;
    tick(12);
    chk1(FLASH.width, 1'b1, "x16 width");
    check_val(USER_RDATA, {img[11], img[10]}, "x16 read");
    USER_X16 = 1'b0;
    tick(12);
    check_val(USER_RDATA, {8'h00, img[10]}, "x8 read");
    {USER_WDATA, USER_OE_N, USER_WE_N} = {lf[15:0], 2'h2};
    tick(6);
    check_val({6'h00, FLASH.we_n, DLO_OE, DLO_O},
              {8'h01, USER_WDATA[7:0]}, "x8 write");
    {USER_CS_N, USER_OE_N, USER_WE_N} = 3'h7;
    $display("test user done");
    prog(50);
    tick(20);
    chk1(DONE_OE, 1'b0, "short request");
    load_img(1'b1);
    MODE = MODE_FLASH_B;
    exp_q.push_back(2'h2);
    prog(130);
    arm;
    fin("check_error");
    chk1(DONE_OE, 1'b1, "done held on error");
    load_img(1'b0);
    {MODE, CHAIN_EN} = {MODE_FLASH_A, 1'b1};
    exp_q.push_back(2'h1);
    prog(130);
    arm;
    fin("chain");
    tick(40);
    chk1(CHAIN_SELECT_OUT_N, 1'b0, "chain select");
    chk1({FLASH.addr, TOP_PIN_O} > 24'(NB), 1'b1, "chain addr");
    load_img(1'b0);
    {MODE, CHAIN_EN} = {MODE_SSER, 1'b0};
    exp_q.push_back(2'h1);
    do_reset;
    arm;
    // Link side sees the load state only after two of its own clocks
    tick(8);
    repeat (2) begin
      #7 SER_CLK = 1'b1;
      #15 SER_CLK = 1'b0;
      #8;
    end
    for (int i = 0; i < NB + STARTUP_SBYT; i++) ser_byte(img[i]);
    fin("serial");
    // After done the stream passes on through the serial output
    ser_byte(8'h00);
    chk1(SER_DOUT, 1'b0, "forwarded bit");
    give_verdict;
  end
endmodule
